// [ctrl_regs_pkg.sv]
package ctrl_regs_pkg;

  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] READOUT_ADDR = 8'h14;
  localparam logic [7:0] TRIGFILT_ADDR = 8'h15;
  localparam logic [7:0] GYROSTAB_ADDR = 8'h16;
  localparam logic [7:0] READOUT_RESET = 8'h00;
  localparam logic [7:0] TRIGFILT_RESET = 8'h00;
  localparam logic [7:0] GYROSTAB_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  // readout_and_selftest_ctrl
  localparam int WRAP_LSB = 5;
  localparam int GYRO_SELFTEST_LSB = 2;
  localparam int ACCEL_SELFTEST_LSB = 0;
  // trigger_and_filter_ctrl
  localparam int EDGE_BIT = 7;
  localparam int LEVEL_BIT = 6;
  localparam int LATCH_BIT = 5;
  localparam int ACCEL_HP_OFF_BIT = 4;
  localparam int OFS_WEIGHT_BIT = 3;
  localparam int LP_BW_LSB = 0;
  // gyro_and_stab_ctrl
  localparam int GYRO_HP_OFF_BIT = 7;
  localparam int HP_EN_BIT = 6;
  localparam int HP_CUT_LSB = 4;
  localparam int STAB_SRC_BIT = 2;
  localparam int OFS_CORR_BIT = 1;
  localparam int STAB_SW_BIT = 0;

  // Highest gyro rate code (1.67 kHz) at which every bandwidth code exists.
  localparam logic [3:0] RATE_CODE_1K67 = 4'h8;

  // ---------------------------------------------------------------
  // Codes and carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SELFTEST_NORMAL = 2'h0,
    SELFTEST_POSITIVE = 2'h1,
    SELFTEST_NEGATIVE = 2'h2,
    SELFTEST_ILLEGAL = 2'h3
  } selftest_e;

  typedef enum logic [2:0] {
    TRIG_NONE = 3'h0,
    TRIG_EDGE = 3'h1,
    TRIG_LEVEL = 3'h2,
    TRIG_LATCHED = 3'h3,
    TRIG_FIFO = 3'h4,
    TRIG_ILLEGAL = 3'h5
  } trig_e;

  localparam logic [2:0] TRIG_CODE_EDGE = 3'h4;
  localparam logic [2:0] TRIG_CODE_LEVEL = 3'h2;
  localparam logic [2:0] TRIG_CODE_LATCHED = 3'h3;
  localparam logic [2:0] TRIG_CODE_FIFO = 3'h6;
  localparam logic [2:0] TRIG_CODE_NONE = 3'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_s;

  typedef struct packed {
    logic wrap_accel;
    logic wrap_gyro;
    selftest_e gyro_selftest;
    selftest_e accel_selftest;
    trig_e trigger_mode;
    logic accel_hiperf_en;
    logic offset_coarse;
    logic [2:0] gyro_lowpass_bw_sel;
    logic gyro_lowpass_active;
    logic gyro_lowpass_bw_valid;
    logic gyro_hiperf_en;
    logic gyro_highpass_active;
    logic [1:0] gyro_highpass_cutoff;
    logic stab_chain_on;
    logic accel_offset_corr_en;
  } sensor_ctrl_s;

endpackage

// [ctrl_byte_reg.sv]
`timescale 1ns/1ps
module ctrl_byte_reg
  import ctrl_regs_pkg::*;
#(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RESET = 8'h00
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register access
  input wire reg_access_s acc,
  output logic [7:0] value
);

  typedef struct packed {
    logic [7:0] value;
  } byte_state_s;

  byte_state_s state_reg;
  byte_state_s state_next;

  // The value holds until rewritten; reserved bits are stored as written.
  always_comb
  begin
    state_next = state_reg;
    if (acc.wr && acc.addr == ADDR)
    begin
      state_next.value = acc.wdata; // RULE17
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '{value: RESET};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg.value;

endmodule

// [sensor_chain_control_regs.sv]
`timescale 1ns/1ps
// How it works
// RULE1: Wrap field picks circular burst-read group.
// RULE2: Gyro self-test: normal, positive, negative; 10 illegal.
// RULE3: Accel self-test: normal, positive, negative; 11 illegal.
// RULE4: Edge, level, latch bits select trigger mode.
// RULE5: Accel performance bit 1 disables high-performance mode.
// RULE6: Offset weight bit picks fine or coarse scale.
// RULE7: Bandwidth codes 100-111 unavailable above 1.67 kHz.
// RULE8: Gyro performance bit 1 disables high-performance mode.
// RULE9: High-pass acts only in gyro high-performance mode.
// RULE10: Two-bit field selects gyro high-pass cutoff.
// RULE11: Control-source bit picks aux port or primary.
// RULE12: Primary switch bit turns stabilization on/off.
// RULE13: Host sets stabilization up via aux port first.
// RULE14: Offset correction enable inserts offset into path.
// RULE15: Host writes zero to reserved bits.
// RULE16: Gyro low-pass acts only with path enable.
// RULE17: Registers hold written value until rewrite/reset.
module sensor_chain_control_regs
  import ctrl_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register access from the serial interface front end
  input wire reg_access_s acc,
  output logic [7:0] rdata,
  output logic rvalid,
  // Context from the rest of the sensor
  input wire logic [3:0] gyro_rate_code,
  input wire logic gyro_lowpass_path_en,
  input wire logic aux_stab_on,
  // Decoded controls
  output sensor_ctrl_s ctrl
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] readout_and_selftest_ctrl;
  logic [7:0] trigger_and_filter_ctrl;
  logic [7:0] gyro_and_stab_ctrl;

  ctrl_byte_reg #(.ADDR(READOUT_ADDR), .RESET(READOUT_RESET)) u_readout (
    .clk(clk),
    .resetn(resetn),
    .acc(acc),
    .value(readout_and_selftest_ctrl)
  );

  ctrl_byte_reg #(.ADDR(TRIGFILT_ADDR), .RESET(TRIGFILT_RESET)) u_trigfilt (
    .clk(clk),
    .resetn(resetn),
    .acc(acc),
    .value(trigger_and_filter_ctrl)
  );

  ctrl_byte_reg #(.ADDR(GYROSTAB_ADDR), .RESET(GYROSTAB_RESET)) u_gyrostab (
    .clk(clk),
    .resetn(resetn),
    .acc(acc),
    .value(gyro_and_stab_ctrl)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
  } read_state_s;

  read_state_s state_reg;
  read_state_s state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = acc.rd;
    if (acc.rd)
    begin
      unique case (acc.addr)
        READOUT_ADDR: state_next.rdata = readout_and_selftest_ctrl; // RULE17
        TRIGFILT_ADDR: state_next.rdata = trigger_and_filter_ctrl; // RULE17
        GYROSTAB_ADDR: state_next.rdata = gyro_and_stab_ctrl; // RULE17
        default: state_next.rdata = UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '{rdata: UNMAPPED_DATA, rvalid: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  assign rvalid = state_reg.rvalid;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic [1:0] gyro_selftest_sel;
  logic [1:0] accel_selftest_sel;
  logic [2:0] trig_code;
  logic gyro_hiperf_on;

  assign gyro_selftest_sel = readout_and_selftest_ctrl[GYRO_SELFTEST_LSB +: 2];
  assign accel_selftest_sel = readout_and_selftest_ctrl[ACCEL_SELFTEST_LSB +: 2];
  assign trig_code = {trigger_and_filter_ctrl[EDGE_BIT], trigger_and_filter_ctrl[LEVEL_BIT],
                      trigger_and_filter_ctrl[LATCH_BIT]};
  assign gyro_hiperf_on = !gyro_and_stab_ctrl[GYRO_HP_OFF_BIT]; // RULE8

  // Forbidden self-test codes are not mapped to normal mode; they decode to
  // SELFTEST_ILLEGAL, so a bad host write is flagged to the rest of the sensor.
  always_comb
  begin
    ctrl = '0;
    ctrl.wrap_accel = readout_and_selftest_ctrl[WRAP_LSB]; // RULE1
    ctrl.wrap_gyro = readout_and_selftest_ctrl[WRAP_LSB + 1]; // RULE1
    unique case (gyro_selftest_sel) // RULE2
      2'b00: ctrl.gyro_selftest = SELFTEST_NORMAL;
      2'b01: ctrl.gyro_selftest = SELFTEST_POSITIVE;
      2'b11: ctrl.gyro_selftest = SELFTEST_NEGATIVE;
      2'b10: ctrl.gyro_selftest = SELFTEST_ILLEGAL;
    endcase
    unique case (accel_selftest_sel) // RULE3
      2'b00: ctrl.accel_selftest = SELFTEST_NORMAL;
      2'b01: ctrl.accel_selftest = SELFTEST_POSITIVE;
      2'b10: ctrl.accel_selftest = SELFTEST_NEGATIVE;
      2'b11: ctrl.accel_selftest = SELFTEST_ILLEGAL;
    endcase
    case (trig_code) // RULE4
      TRIG_CODE_NONE: ctrl.trigger_mode = TRIG_NONE;
      TRIG_CODE_EDGE: ctrl.trigger_mode = TRIG_EDGE;
      TRIG_CODE_LEVEL: ctrl.trigger_mode = TRIG_LEVEL;
      TRIG_CODE_LATCHED: ctrl.trigger_mode = TRIG_LATCHED;
      TRIG_CODE_FIFO: ctrl.trigger_mode = TRIG_FIFO;
      default: ctrl.trigger_mode = TRIG_ILLEGAL;
    endcase
    ctrl.accel_hiperf_en = !trigger_and_filter_ctrl[ACCEL_HP_OFF_BIT]; // RULE5
    ctrl.offset_coarse = trigger_and_filter_ctrl[OFS_WEIGHT_BIT]; // RULE6
    ctrl.gyro_lowpass_bw_sel = trigger_and_filter_ctrl[LP_BW_LSB +: 3];
    ctrl.gyro_lowpass_active = gyro_lowpass_path_en; // RULE16
    ctrl.gyro_lowpass_bw_valid = !(trigger_and_filter_ctrl[LP_BW_LSB + 2]
                                   && gyro_rate_code > RATE_CODE_1K67); // RULE7
    ctrl.gyro_hiperf_en = gyro_hiperf_on; // RULE8
    ctrl.gyro_highpass_active = gyro_and_stab_ctrl[HP_EN_BIT] && gyro_hiperf_on; // RULE9
    ctrl.gyro_highpass_cutoff = gyro_and_stab_ctrl[HP_CUT_LSB +: 2]; // RULE10
    // With the source bit low the aux port owns the chain, which also
    // covers the initial setup that must go through that port.
    ctrl.stab_chain_on = gyro_and_stab_ctrl[STAB_SRC_BIT] ? // RULE11
                         gyro_and_stab_ctrl[STAB_SW_BIT] : aux_stab_on; // RULE12 RULE13
    ctrl.accel_offset_corr_en = gyro_and_stab_ctrl[OFS_CORR_BIT]; // RULE14
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  wrap_write_a: assert property (acc.wr && acc.addr == READOUT_ADDR |=> // RULE1
      {ctrl.wrap_gyro, ctrl.wrap_accel} == $past(acc.wdata[WRAP_LSB +: 2]))
    else $error("wrap field not taken from write");
  gyro_selftest_a: assert property ((ctrl.gyro_selftest == SELFTEST_NEGATIVE) // RULE2
      == (readout_and_selftest_ctrl[GYRO_SELFTEST_LSB +: 2] == 2'b11))
    else $error("gyro negative self-test decode wrong");
  accel_selftest_a: assert property ((ctrl.accel_selftest == SELFTEST_NEGATIVE) // RULE3
      == (readout_and_selftest_ctrl[ACCEL_SELFTEST_LSB +: 2] == 2'b10))
    else $error("accel negative self-test decode wrong");
  trig_edge_a: assert property (acc.wr && acc.addr == TRIGFILT_ADDR // RULE4
      && acc.wdata[7:5] == 3'b100 |=> ctrl.trigger_mode == TRIG_EDGE)
    else $error("edge trigger mode not selected");
  accel_hiperf_a: assert property (acc.wr && acc.addr == TRIGFILT_ADDR // RULE5
      |=> ctrl.accel_hiperf_en != $past(acc.wdata[ACCEL_HP_OFF_BIT]))
    else $error("accel high-performance enable wrong");
  lowpass_bw_a: assert property (trigger_and_filter_ctrl[LP_BW_LSB + 2] // RULE7
      && gyro_rate_code >= 4'h9 |-> !ctrl.gyro_lowpass_bw_valid)
    else $error("bandwidth code allowed at high rate");
  gyro_highpass_a: assert property (acc.wr && acc.addr == GYROSTAB_ADDR |=> // RULE9
      ctrl.gyro_highpass_active == ($past(acc.wdata[HP_EN_BIT])
      && !$past(acc.wdata[GYRO_HP_OFF_BIT])))
    else $error("high-pass active outside high-performance mode");
  offset_weight_a: assert property (acc.wr && acc.addr == TRIGFILT_ADDR // RULE6
      |=> ctrl.offset_coarse == $past(acc.wdata[OFS_WEIGHT_BIT]))
    else $error("offset weight not taken from write");
  gyro_hiperf_a: assert property (acc.wr && acc.addr == GYROSTAB_ADDR // RULE8
      |=> ctrl.gyro_hiperf_en != $past(acc.wdata[GYRO_HP_OFF_BIT]))
    else $error("gyro high-performance enable wrong");
  hp_cutoff_a: assert property (acc.wr && acc.addr == GYROSTAB_ADDR // RULE10
      |=> ctrl.gyro_highpass_cutoff == $past(acc.wdata[HP_CUT_LSB +: 2]))
    else $error("high-pass cutoff not taken from write");
  stab_aux_a: assert property (!gyro_and_stab_ctrl[STAB_SRC_BIT] // RULE11
      |-> ctrl.stab_chain_on == aux_stab_on)
    else $error("aux port does not own stabilization");
  offset_corr_a: assert property (acc.wr && acc.addr == GYROSTAB_ADDR // RULE14
      |=> ctrl.accel_offset_corr_en == $past(acc.wdata[OFS_CORR_BIT]))
    else $error("offset correction enable not taken from write");
  lowpass_path_a: assert property (ctrl.gyro_lowpass_active // RULE16
      == gyro_lowpass_path_en)
    else $error("low-pass active without path enable");
  hold_value_a: assert property (!(acc.wr && acc.addr == GYROSTAB_ADDR) // RULE17
      |=> $stable(gyro_and_stab_ctrl))
    else $error("register changed without a write");
  stab_switch_a: assert property (acc.wr && acc.addr == GYROSTAB_ADDR // RULE12
      && acc.wdata[STAB_SRC_BIT] |=> ctrl.stab_chain_on == $past(acc.wdata[STAB_SW_BIT]))
    else $error("stabilization switch not followed");
  read_back_a: assert property (acc.wr && acc.addr == TRIGFILT_ADDR ##1 // RULE17
      (acc.rd && !acc.wr && acc.addr == TRIGFILT_ADDR) |=> rvalid && rdata == $past(acc.wdata, 2))
    else $error("read does not return last write");

  write_read_c: cover property (acc.wr ##1 acc.rd ##1 rvalid);
  selftest_neg_c: cover property (ctrl.gyro_selftest == SELFTEST_NEGATIVE);
  stab_primary_c: cover property (gyro_and_stab_ctrl[STAB_SRC_BIT] && ctrl.stab_chain_on);
  fifo_trig_c: cover property (ctrl.trigger_mode == TRIG_FIFO);

endmodule

// [host_port_model.sv]
`timescale 1ns/1ps
module host_port_model
  import ctrl_regs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register access toward the device
  output reg_access_s acc,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // ---------------------------------------------------------------
  // Host side of the parallel register port
  // ---------------------------------------------------------------
  initial acc = '0;

  // Reserved positions are forced low, since a set bit there upsets the sensor.
  function automatic logic [7:0] clean(input logic [7:0] a, input logic [7:0] d);
    case (a)
      READOUT_ADDR: clean = d & 8'h6f;
      GYROSTAB_ADDR: clean = d & 8'hf7;
      default: clean = d;
    endcase
  endfunction

  // One request per call; address and data are scrambled once released.
  task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
    @(posedge clk);
    #1;
    acc = '{wr: w, rd: r, addr: a, wdata: clean(a, d)};
    @(posedge clk);
    #1;
    acc.wr = 1'b0;
    acc.rd = 1'b0;
    acc.addr = ~a;
    acc.wdata = ~acc.wdata;
    q = rdata;
    v = rvalid;
  endtask

  // Write, then read the same register on the very next edge with no idle cycle.
  task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    acc = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: clean(a, d)};
    @(posedge clk);
    #1;
    acc.wr = 1'b0;
    acc.rd = 1'b1;
    @(posedge clk);
    #1;
    acc.rd = 1'b0;
    acc.addr = ~a;
    q = rdata;
  endtask
endmodule

// [sensor_chain_control_regs_tb_top.sv]
`timescale 1ns/1ps
module sensor_chain_control_regs_tb_top
  import ctrl_regs_pkg::*;
();
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] gyro_rate_code = 4'h9;
  logic gyro_lowpass_path_en = 1'b0;
  logic aux_stab_on = 1'b0;
  reg_access_s acc;
  logic [7:0] rdata;
  logic rvalid;
  sensor_ctrl_s ctrl;
  int miscompares = 0;
  int samples_checked = 0;
  logic [7:0] q;
  logic v;
  selftest_e g_exp [4] = '{SELFTEST_NORMAL, SELFTEST_POSITIVE, SELFTEST_ILLEGAL,
                           SELFTEST_NEGATIVE};
  selftest_e a_exp [4] = '{SELFTEST_NORMAL, SELFTEST_POSITIVE, SELFTEST_NEGATIVE,
                           SELFTEST_ILLEGAL};
  trig_e t_exp [8] = '{TRIG_NONE, TRIG_ILLEGAL, TRIG_LEVEL, TRIG_LATCHED,
                       TRIG_EDGE, TRIG_ILLEGAL, TRIG_FIFO, TRIG_ILLEGAL};

  always #12.5 clk = ~clk;

  sensor_chain_control_regs u_dut (.clk(clk), .resetn(resetn), .acc(acc), .rdata(rdata),
    .rvalid(rvalid), .gyro_rate_code(gyro_rate_code),
    .gyro_lowpass_path_en(gyro_lowpass_path_en), .aux_stab_on(aux_stab_on), .ctrl(ctrl));
  host_port_model u_host (.clk(clk), .acc(acc), .rdata(rdata), .rvalid(rvalid));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'b1, 1'b0, a, d, q, v);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    u_host.access(1'b0, 1'b1, a, 8'h00, q, v);
    chk("rvalid", v, 1'b1);
    chk(name, q, exp);
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    rd_chk("readout", READOUT_ADDR, READOUT_RESET);
    rd_chk("trigfilt", TRIGFILT_ADDR, TRIGFILT_RESET);
    rd_chk("gyrostab", GYROSTAB_ADDR, GYROSTAB_RESET);
    chk("wrap", {ctrl.wrap_gyro, ctrl.wrap_accel}, 2'b00);
    chk("gyro_selftest", ctrl.gyro_selftest, SELFTEST_NORMAL);
    chk("accel_selftest", ctrl.accel_selftest, SELFTEST_NORMAL);
    chk("trig", ctrl.trigger_mode, TRIG_NONE);
    chk("accel_hp", ctrl.accel_hiperf_en, 1'b1);
    chk("gyro_hp", ctrl.gyro_hiperf_en, 1'b1);
    chk("hpf", ctrl.gyro_highpass_active, 1'b0);
    chk("cutoff", ctrl.gyro_highpass_cutoff, 2'b00);
    chk("corr", ctrl.accel_offset_corr_en, 1'b0);
  endtask

  task automatic test_readout();
    logic [1:0] c;
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      d = {1'b0, c, 1'b0, c, c};
      wr(READOUT_ADDR, d);
      chk("wrap", {ctrl.wrap_gyro, ctrl.wrap_accel}, c);
      chk("gyro_selftest", ctrl.gyro_selftest, g_exp[i]);
      chk("accel_selftest", ctrl.accel_selftest, a_exp[i]);
      rd_chk("readout", READOUT_ADDR, d);
    end
  endtask

  task automatic test_trigger();
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      wr(TRIGFILT_ADDR, {c, c[1], c[0], c});
      gyro_lowpass_path_en = c[0];
      settle();
      chk("trig", ctrl.trigger_mode, t_exp[i]);
      chk("accel_hp", ctrl.accel_hiperf_en, !c[1]);
      chk("weight", ctrl.offset_coarse, c[0]);
      chk("bw", ctrl.gyro_lowpass_bw_sel, c);
      chk("bw_valid", ctrl.gyro_lowpass_bw_valid, !c[2]);
      chk("lp_act", ctrl.gyro_lowpass_active, c[0]);
    end
    gyro_rate_code = RATE_CODE_1K67;
    settle();
    chk("bw_valid", ctrl.gyro_lowpass_bw_valid, 1'b1);
  endtask

  task automatic test_gyro();
    logic [3:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      wr(GYROSTAB_ADDR, {c, 2'b00, c[0], 1'b0});
      chk("gyro_hp", ctrl.gyro_hiperf_en, !c[3]);
      chk("hpf", ctrl.gyro_highpass_active, c[2] && !c[3]);
      chk("cutoff", ctrl.gyro_highpass_cutoff, c[1:0]);
      chk("corr", ctrl.accel_offset_corr_en, c[0]);
    end
  endtask

  task automatic test_stab();
    wr(GYROSTAB_ADDR, 8'h00);
    aux_stab_on = 1'b1;
    settle();
    chk("stab", ctrl.stab_chain_on, 1'b1);
    aux_stab_on = 1'b0;
    settle();
    chk("stab", ctrl.stab_chain_on, 1'b0);
    wr(GYROSTAB_ADDR, 8'h05);
    chk("stab", ctrl.stab_chain_on, 1'b1);
    wr(GYROSTAB_ADDR, 8'h04);
    aux_stab_on = 1'b1;
    settle();
    chk("stab", ctrl.stab_chain_on, 1'b0);
  endtask

  task automatic test_map();
    wr(8'h17, 8'hff);
    rd_chk("unmapped", 8'h17, UNMAPPED_DATA);
    rd_chk("unmapped", 8'h13, UNMAPPED_DATA);
    rd_chk("gyrostab", GYROSTAB_ADDR, 8'h04);
    u_host.access(1'b1, 1'b1, GYROSTAB_ADDR, 8'h30, q, v);
    chk("old_value", q, 8'h04);
    settle();
    chk("rvalid_drop", rvalid, 1'b0);
    rd_chk("gyrostab", GYROSTAB_ADDR, 8'h30);
    u_host.write_read(TRIGFILT_ADDR, 8'h6a, q);
    chk("write_read", q, 8'h6a);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    test_reset();
    test_readout();
    test_trigger();
    test_gyro();
    test_stab();
    test_map();
    end_of_test();
  end

  initial
  begin
    #200_000;
    miscompares++;
    end_of_test();
  end
endmodule
